// >>> design/dac_pkg.sv
// What this block does
// - Clear low empties shifter, zeroes both latches
// - After clear output sits at zero volts, or at the negative reference in bipolar offset binary
// - Sixteen-bit frames, data sampled on falling clock
// - Three ignored bits, select, 12-bit code MSB-first
// - Bit twelve picks channel latch
// - Two deferred writes, strobe low updates both
// - Strobe low: latch updates on sixteenth edge
// - Coding high bipolar: twos complement code
// - Coding low bipolar: offset binary code
// - Unipolar coding low: natural binary code
// - Count sixteen edges, ignore further clocks
// - Strobe level at frame start picks update mode
package dac_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int CHAN_POS = 12;
    localparam logic [4:0] FRAME_LAST = 5'h0f;
    localparam logic [4:0] FRAME_FULL = 5'h10;
    localparam logic [11:0] CODE_MSB = 12'h800;

    typedef struct packed {
        logic [2:0] ignored;
        logic channel_select_bit;
        logic [11:0] code;
    } frame_t;

    // ----------------------------------------------------------------
    // Register map and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] LATCH_A_OFS = 8'h08;
    localparam logic [7:0] LATCH_B_OFS = 8'h0c;
    localparam logic [7:0] HOLD_A_OFS = 8'h10;
    localparam logic [7:0] HOLD_B_OFS = 8'h14;
    localparam int CTRL_CODING_POS = 0;
    localparam int CTRL_BIPOLAR_POS = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [11:0] CODE_RESET = 12'h000;

    typedef struct packed {
        logic bipolar;
        logic coding_select;
    } cfg_t;

endpackage : dac_pkg

// >>> design/dual_dac_serial_load_clear.sv
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dual_dac_serial_load_clear (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic host_frame_sync_n,
    input wire logic load_strobe_n,
    input wire logic clear_n,
    output logic [11:0] dac_a_level,
    output logic [11:0] dac_b_level
);

    // ----------------------------------------------------------------
    // Link domain: shift register on the falling serial clock
    // ----------------------------------------------------------------
    // All link logic but the abort lock runs on the falling serial clock edge.
    // The host may stop its clock between frames.
    // Nothing here may depend on a clock edge outside a frame.
    // Clear acts as a level; frame sync acts as a level, and its fall also clocks the abort lock.
    // A burst clock and a free-running clock must both work.
    // The counter therefore locks after the sixteenth edge.
    // Only the completed word and its toggle leave this domain.
    logic [15:0] shift_ff;
    logic [4:0] bit_cnt_ff;
    dac_pkg::frame_t word_ff;
    logic word_tgl_ff;
    logic link_clr_n;
    logic cnt_rst_n;
    logic abort_ff;

    // Clear acts at once on the link side, without waiting for a clock
    assign link_clr_n = hresetn & clear_n;
    // Frame sync high or clear rearms the counter for a fresh frame
    assign cnt_rst_n = link_clr_n & ~host_frame_sync_n;

    // A clear inside a frame locks out the rest of that frame.
    // Without this lock the edges left after clear is released would
    // start a new count in mid-frame and could land a shifted word.
    // The lock is lifted by the next frame sync fall, so a clear that
    // comes between frames costs nothing to the following frame.
    // Clear held across a frame sync fall keeps that frame locked too.
    always_ff @(negedge host_frame_sync_n or negedge link_clr_n) begin
        if (!link_clr_n) begin
            abort_ff <= 1'b1;
        end else begin
            abort_ff <= 1'b0;
        end
    end

    // Bit counter gates the shifter after sixteen edges
    // It stops at the full count, so stray clocks after the word
    // neither shift nor wrap the count back to zero.
    always_ff @(negedge serial_clk or negedge cnt_rst_n) begin
        if (!cnt_rst_n) begin
            bit_cnt_ff <= 5'h00;
        end else if (!abort_ff && bit_cnt_ff != dac_pkg::FRAME_FULL) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    // Data sampled on the falling edge, MSB first
    always_ff @(negedge serial_clk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            shift_ff <= 16'h0000;
        end else if (!abort_ff && bit_cnt_ff != dac_pkg::FRAME_FULL) begin
            shift_ff <= {shift_ff[14:0], serial_data_in};
        end
    end

    // Completed word is held stable for a whole frame, so the bus side
    // can read it after the toggle settles; clear must not fake a toggle
    always_ff @(negedge serial_clk or negedge hresetn) begin
        if (!hresetn) begin
            word_ff <= '0;
            word_tgl_ff <= 1'b0;
        end else if (bit_cnt_ff == dac_pkg::FRAME_LAST && link_clr_n && !abort_ff) begin
            word_ff <= {shift_ff[14:0], serial_data_in};
            word_tgl_ff <= ~word_tgl_ff;
        end
    end

    // ----------------------------------------------------------------
    // Crossing into the bus clock
    // ----------------------------------------------------------------
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic [3:0] prev_ff;
    logic fs_fall;
    logic ld_fall;
    logic word_done;
    logic clr_active;

    // Two flops on every pin and on the word toggle
    // The word itself crosses as a bundle: it is held still for at
    // least a frame, and only its toggle is synchronised, so no bit of
    // the word is ever sampled while it moves.
    // Reset values are the idle pin levels, but the toggle bit also resets high, so one false word edge follows.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= 4'hf;
            sync_ff <= 4'hf;
            prev_ff <= 4'hf;
        end else begin
            meta_ff <= {clear_n, load_strobe_n, host_frame_sync_n, word_tgl_ff};
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign word_done = sync_ff[0] ^ prev_ff[0];
    assign fs_fall = prev_ff[1] & ~sync_ff[1];
    assign ld_fall = prev_ff[2] & ~sync_ff[2];
    assign clr_active = ~sync_ff[3];

    // ----------------------------------------------------------------
    // Update mode, input holds and channel latches
    // ----------------------------------------------------------------
    logic auto_mode_ff;
    logic [11:0] hold_a_ff;
    logic [11:0] hold_b_ff;
    logic [11:0] latch_a_ff;
    logic [11:0] latch_b_ff;
    dac_pkg::frame_t rx_word;

    // Word is stable here: its toggle has passed two flops
    assign rx_word = word_ff;

    // Strobe level just after frame sync falls chooses the mode
    // Both pins pass the same flops, so their relative order is kept.
    // The host must settle the strobe before frame sync falls.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_mode_ff <= 1'b0;
        end else if (fs_fall) begin
            auto_mode_ff <= ~sync_ff[2];
        end
    end

    // Holds take every word; clear wins over any arriving word
    // The holds let a deferred update load both channels at once.
    // They are zeroed by clear as well, so a later strobe fall cannot
    // bring back a code written before the clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_a_ff <= dac_pkg::CODE_RESET;
            hold_b_ff <= dac_pkg::CODE_RESET;
        end else if (clr_active) begin
            hold_a_ff <= dac_pkg::CODE_RESET;
            hold_b_ff <= dac_pkg::CODE_RESET;
        end else if (word_done) begin
            if (rx_word.channel_select_bit) begin
                hold_b_ff <= rx_word.code;
            end else begin
                hold_a_ff <= rx_word.code;
            end
        end
    end

    // Auto mode writes the chosen latch; a strobe fall loads both
    // Priority: clear, then strobe fall, then an arriving word.
    // A strobe fall in auto mode reloads both latches from the holds,
    // which in auto mode already equal the latches.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_a_ff <= dac_pkg::CODE_RESET;
            latch_b_ff <= dac_pkg::CODE_RESET;
        end else if (clr_active) begin
            latch_a_ff <= dac_pkg::CODE_RESET;
            latch_b_ff <= dac_pkg::CODE_RESET;
        end else if (ld_fall) begin
            latch_a_ff <= hold_a_ff;
            latch_b_ff <= hold_b_ff;
        end else if (word_done && auto_mode_ff) begin
            if (rx_word.channel_select_bit) begin
                latch_b_ff <= rx_word.code;
            end else begin
                latch_a_ff <= rx_word.code;
            end
        end
    end

    // ----------------------------------------------------------------
    // Code to converter level (0 is the lowest output of the range)
    // ----------------------------------------------------------------
    dac_pkg::cfg_t cfg_ff;
    logic [11:0] flip_mask;

    // Twos complement only in the bipolar range; a zero latch then
    // lands at mid-scale, which is zero volts
    // Offset binary keeps a zero latch at the lowest level, the
    // negative reference; unipolar ranges keep it at zero volts.
    // Coding high in a unipolar range is taken as natural binary.
    assign flip_mask = (cfg_ff.bipolar && cfg_ff.coding_select) ?
        dac_pkg::CODE_MSB : 12'h000;

    // Offset binary and natural binary pass the code straight through
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_a_level <= dac_pkg::CODE_RESET;
            dac_b_level <= dac_pkg::CODE_RESET;
        end else begin
            dac_a_level <= latch_a_ff ^ flip_mask;
            dac_b_level <= latch_b_ff ^ flip_mask;
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ----------------------------------------------------------------
    logic addr_ok;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] rd_word;

    assign addr_ok = hsel & htrans[1] & hready;

    // Read data is formed in the address phase so it stands in the data phase
    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr)
            dac_pkg::CTRL_OFS: rd_word = {30'h0, cfg_ff};
            dac_pkg::STATUS_OFS: rd_word = {29'h0, clr_active, ~sync_ff[1], auto_mode_ff};
            dac_pkg::LATCH_A_OFS: rd_word = {20'h0, latch_a_ff};
            dac_pkg::LATCH_B_OFS: rd_word = {20'h0, latch_b_ff};
            dac_pkg::HOLD_A_OFS: rd_word = {20'h0, hold_a_ff};
            dac_pkg::HOLD_B_OFS: rd_word = {20'h0, hold_b_ff};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Address phase capture
    // Read data is registered here so it stands through the data
    // phase and on until the next read address phase.
    // Write address is kept for the data phase, when hwdata stands.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_ff <= haddr;
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    // Data phase write of the range and coding controls
    // Only the control word is writable; other writes are ignored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff <= dac_pkg::CTRL_RESET;
        end else if (wr_pend_ff && wr_addr_ff == dac_pkg::CTRL_OFS) begin
            cfg_ff.coding_select <= hwdata[dac_pkg::CTRL_CODING_POS];
            cfg_ff.bipolar <= hwdata[dac_pkg::CTRL_BIPOLAR_POS];
        end
    end

    // Never stalls and never errors
    // Kept as flops so every output comes from a register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : dual_dac_serial_load_clear

// >>> tb/dac_monitor.sv
`timescale 1ns/1ps
module dac_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic host_frame_sync_n,
    input wire logic load_strobe_n,
    input wire logic clear_n,
    input wire logic [11:0] dac_a_level,
    input wire logic [11:0] dac_b_level
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Taken bus cycles; a coding write may legally move both levels
    logic rd_take;
    logic wr_take;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign wr_take = hsel && htrans[1] && hready && hwrite;
    // Clear held long enough to cross the two sync flops
    sequence s_cleared;
        (!clear_n && !wr_take)[*6];
    endsequence
    // Link idle and strobe high long enough for any update to land
    sequence s_idle;
        (host_frame_sync_n && load_strobe_n && clear_n && !wr_take)[*7];
    endsequence
    // Auto mode without a strobe fall: one word lands at a time
    sequence s_auto;
        (!load_strobe_n && clear_n && !wr_take)[*7];
    endsequence
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
        else $error("hrdata moved");
    a_clear_equal: assert property (s_cleared |-> dac_a_level == dac_b_level)
        else $error("levels differ in clear");
    a_clear_code: assert property (s_cleared |-> dac_a_level inside {12'h000, 12'h800})
        else $error("clear level wrong");
    a_clear_holds: assert property (s_cleared |=> $stable(dac_a_level))
        else $error("level moved in clear");
    a_idle_still: assert property (s_idle |-> $stable(dac_a_level) && $stable(dac_b_level))
        else $error("level moved while idle");
    a_one_channel: assert property (s_auto |-> !($changed(dac_a_level) && $changed(dac_b_level)))
        else $error("both levels moved in auto");
endmodule : dac_monitor
bind dual_dac_serial_load_clear dac_monitor mon_u (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .host_frame_sync_n, .load_strobe_n, .clear_n,
    .dac_a_level, .dac_b_level);

// >>> tb/host_port.sv
`timescale 1ns/1ps
module host_port (
    output logic serial_clk,
    output logic serial_data_in,
    output logic host_frame_sync_n
);
    // Clock stands high between frames
    initial begin
        serial_clk = 1'h1;
        serial_data_in = 1'h0;
        host_frame_sync_n = 1'h1;
    end
    // Data moves on the rising edge so the falling edge sees it settled
    task automatic send(input dac_pkg::frame_t f, input int extra);
        logic [15:0] w;
        w = f;
        #7 host_frame_sync_n = 1'h0;
        #160;
        for (int i = 15; i >= -extra; i--) begin
            serial_data_in = (i >= 0) ? w[i] : ~serial_data_in;
            #16 serial_clk = 1'h0;
            #16 serial_clk = 1'h1;
        end
        host_frame_sync_n = 1'h1;
        serial_data_in = ~serial_data_in;
        #200;
    endtask : send
endmodule : host_port

// >>> tb/tb_dual_dac_serial_load_clear.sv
`timescale 1ns/1ps
module tb_dual_dac_serial_load_clear;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic load_strobe_n = 1'h0, clear_n = 1'h1;
    logic hreadyout, hresp, serial_clk, serial_data_in, host_frame_sync_n;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0, cfg = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, q, rnd = 32'h31a9;
    logic [11:0] dac_a_level, dac_b_level, c, exp_a = 12'h0, exp_b = 12'h0;
    int failures = 0, comparisons = 0;
    // Bus clock, 40 ns
    always #20 hclk = ~hclk;
    dual_dac_serial_load_clear dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .serial_clk, .serial_data_in, .host_frame_sync_n, .load_strobe_n,
        .clear_n, .dac_a_level, .dac_b_level);
    host_port host_u (.serial_clk, .serial_data_in, .host_frame_sync_n);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Only bipolar twos complement shifts the code by half scale
    function automatic logic [31:0] level(input logic [11:0] v);
        return {20'h0, (cfg == 2'h3) ? v ^ dac_pkg::CODE_MSB : v};
    endfunction : level
    task automatic summarize;
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // Single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask : bus
    task automatic chk;
        bus(dac_pkg::LATCH_A_OFS, 1'h0, 32'h0);
        cmp("latch_a", {20'h0, exp_a}, q);
        bus(dac_pkg::LATCH_B_OFS, 1'h0, 32'h0);
        cmp("latch_b", {20'h0, exp_b}, q);
        cmp("level_a", level(exp_a), {20'h0, dac_a_level});
        cmp("level_b", level(exp_b), {20'h0, dac_b_level});
    endtask : chk
    // Send a word, then give it time to cross into the bus domain
    task automatic frame(input logic b, input logic [11:0] v, input int x);
        host_u.send({rnd[15:13], b, v}, x);
        repeat (7) @(posedge hclk);
    endtask : frame
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (3) @(posedge hclk);
        bus(dac_pkg::CTRL_OFS, 1'h0, 32'h0);
        cmp("ctrl", 32'h0, q);
        bus(dac_pkg::STATUS_OFS, 1'h0, 32'h0);
        cmp("status", 32'h0, q);
        bus(8'h20, 1'h1, 32'hffffffff);
        bus(8'h20, 1'h0, 32'h0);
        cmp("unmapped", 32'h0, q);
        chk;
        // Auto update, corner codes first, stray clocks after the word
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            c = (i == 0) ? 12'h7ff : (i == 1) ? 12'h800 : rnd[11:0];
            frame(rnd[12], c, rnd[17:16]);
            if (rnd[12]) exp_b = c;
            else exp_a = c;
            chk;
        end
        bus(dac_pkg::STATUS_OFS, 1'h0, 32'h0);
        cmp("status", 32'h1, q);
        // Every coding and range setting
        for (int m = 0; m < 4; m++) begin
            cfg = m[1:0];
            bus(dac_pkg::CTRL_OFS, 1'h1, {30'h0, cfg});
            bus(dac_pkg::CTRL_OFS, 1'h0, 32'h0);
            cmp("ctrl", {30'h0, cfg}, q);
            chk;
        end
        // Deferred: two words, then one strobe fall loads both
        load_strobe_n <= 1'h1;
        rnd = lfsr(rnd);
        frame(1'h0, rnd[11:0], 0);
        frame(1'h1, rnd[27:16], 0);
        chk;
        bus(dac_pkg::HOLD_A_OFS, 1'h0, 32'h0);
        cmp("hold_a", {20'h0, rnd[11:0]}, q);
        bus(dac_pkg::HOLD_B_OFS, 1'h0, 32'h0);
        cmp("hold_b", {20'h0, rnd[27:16]}, q);
        load_strobe_n <= 1'h0;
        exp_a = rnd[11:0];
        exp_b = rnd[27:16];
        repeat (5) @(posedge hclk);
        chk;
        load_strobe_n <= 1'h1;
        @(posedge hclk);
        load_strobe_n <= 1'h0;
        // Clear in mid-frame; the tail of that frame must not land
        rnd = lfsr(rnd);
        fork
            frame(1'h0, rnd[11:0], 20);
            begin
                repeat (8) @(posedge hclk);
                clear_n <= 1'h0;
                repeat (6) @(posedge hclk);
                clear_n <= 1'h1;
            end
        join
        exp_a = 12'h0;
        exp_b = 12'h0;
        chk;
        rnd = lfsr(rnd);
        frame(1'h1, rnd[11:0], 0);
        exp_b = rnd[11:0];
        chk;
        summarize;
    end
    // Watchdog
    initial begin
        #300000;
        failures++;
        summarize;
    end
endmodule : tb_dual_dac_serial_load_clear
